// >>> design/sal_top.sv
// Function
// - The averaging count takes any value 1 to 50000 and the mean spans that many samples.
// - A count of one passes every sample straight on, one update per conversion.
// - With averaging on, the output updates once per finished group.
// - Smoothing is a first-order digital low-pass acting on the averaged stream, one step per mean.
// - Cut-off is off, 5, 10, 25, 50, 100, 200, 400 Hz or 1 kHz.
// - Each cut-off uses a fixed gain that puts the -3 dB point at that frequency for a 10 kHz step rate; the averaging count does not rescale it.
// - Software writes cut-off, averaging count and tare and the output path obeys them.
// - Processed values are also delivered to software beside the out_data stream.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sal_cfg.svh"
module sal_top
  import sal_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          in_valid,
  input  wire sal_sample_t   in_data,
  output logic               in_ready,
  output logic               out_valid,
  output sal_sample_t        out_data,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  function automatic logic [16:0] sal_coef(input logic [3:0] sel);
    case (sel)
      4'h1: sal_coef = `SAL_COEF_5;
      4'h2: sal_coef = `SAL_COEF_10;
      4'h3: sal_coef = `SAL_COEF_25;
      4'h4: sal_coef = `SAL_COEF_50;
      4'h5: sal_coef = `SAL_COEF_100;
      4'h6: sal_coef = `SAL_COEF_200;
      4'h7: sal_coef = `SAL_COEF_400;
      4'h8: sal_coef = `SAL_COEF_1K;
      default: sal_coef = 17'h0;
    endcase
  endfunction : sal_coef

  function automatic sal_sample_t sal_sat16(input logic signed [16:0] v);
    if (v > 17'sh07fff)
      sal_sat16 = 16'sh7fff;
    else if (v < -17'sh08000)
      sal_sat16 = -16'sh8000;
    else
      sal_sat16 = v[15:0];
  endfunction : sal_sat16

  sal_state_e          st_reg;
  logic [3:0]          filt_reg;
  logic [15:0]         avg_reg;
  logic [15:0]         cnt_reg;
  logic signed [31:0]  sum_reg;
  logic [31:0]         dvd_reg;
  logic [16:0]         rem_reg;
  logic [4:0]          step_reg;
  logic                neg_reg;
  sal_sample_t         x_reg;
  logic signed [31:0]  y_reg;
  sal_sample_t         pre_reg;
  sal_sample_t         tare_reg;
  logic                aw_hold_reg;
  logic                w_hold_reg;
  logic [7:0]          awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                in_hs;
  logic                wr_go;
  logic                ar_hs;
  logic                avg_restart;
  logic                tare_set;
  logic                tare_clr;
  logic                filt_on;
  logic signed [31:0]  sum_add;
  logic [16:0]         trial;
  logic                sub_ok;
  logic [16:0]         quo;
  logic signed [32:0]  diff;
  logic signed [50:0]  prod;
  logic signed [31:0]  y_next;
  logic [15:0]         avg_wr;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  sal_sample_t         fifo_out_data;
  logic                fifo_pop;
  logic [4:0]          fifo_level;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  assign s_axi_awready = ce && !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign wr_go         = ce && aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign fifo_pop      = ar_hs && (s_axi_araddr == `SAL_OFS_DATA);
  assign avg_wr        = {wstrb_reg[1] ? wdata_reg[15:8] : avg_reg[15:8],
                          wstrb_reg[0] ? wdata_reg[7:0] : avg_reg[7:0]};
  assign tare_set = wr_go && awaddr_reg == `SAL_OFS_TARE && wstrb_reg[0]
                    && wdata_reg[`SAL_TARE_SET_BIT];
  assign tare_clr = wr_go && awaddr_reg == `SAL_OFS_TARE && wstrb_reg[0]
                    && wdata_reg[`SAL_TARE_CLR_BIT];
  assign avg_restart = wr_go && awaddr_reg == `SAL_OFS_AVG;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 8'h0;
      wdata_reg    <= 32'h0;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SAL_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg == `SAL_OFS_FILT || awaddr_reg == `SAL_OFS_AVG
                         || awaddr_reg == `SAL_OFS_TARE) ? `SAL_RESP_OKAY : `SAL_RESP_SLV;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_reg <= `SAL_RST_FILT;
      avg_reg  <= `SAL_RST_AVG;
    end
    else if (wr_go && awaddr_reg == `SAL_OFS_FILT && wstrb_reg[0])
    begin
      filt_reg <= wdata_reg[3:0];
    end
    else if (avg_restart)
    begin
      if (avg_wr < `SAL_AVG_MIN)
        avg_reg <= `SAL_AVG_MIN;
      else if (avg_wr > `SAL_AVG_MAX)
        avg_reg <= `SAL_AVG_MAX;
      else
        avg_reg <= avg_wr;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `SAL_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SAL_RESP_OKAY;
        case (s_axi_araddr)
          `SAL_OFS_FILT:  s_axi_rdata <= {28'h0, filt_reg};
          `SAL_OFS_AVG:   s_axi_rdata <= {16'h0, avg_reg};
          `SAL_OFS_TARE:  s_axi_rdata <= {{16{tare_reg[15]}}, tare_reg};
          `SAL_OFS_VALUE: s_axi_rdata <= {{16{out_data[15]}}, out_data};
          `SAL_OFS_DATA:  s_axi_rdata <= fifo_out_valid
                                         ? {{16{fifo_out_data[15]}}, fifo_out_data} : 32'h0;
          `SAL_OFS_STAT:  s_axi_rdata <= {22'h0, !fifo_in_ready, !fifo_out_valid,
                                          3'h0, fifo_level};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SAL_RESP_SLV;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Averager and divider.

  // A sample is refused in the cycle that restarts the group, so it is never taken and lost.
  assign in_ready = ce && st_reg == st_idle && !avg_restart;
  assign in_hs    = in_valid && in_ready;
  assign sum_add  = sum_reg + {{16{in_data[15]}}, in_data};
  assign trial    = {rem_reg[15:0], dvd_reg[31]};
  assign sub_ok   = trial >= {1'b0, avg_reg};
  assign quo      = dvd_reg[16:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg   <= st_idle;
      cnt_reg  <= 16'h0;
      sum_reg  <= 32'sh0;
      dvd_reg  <= 32'h0;
      rem_reg  <= 17'h0;
      step_reg <= 5'h0;
      neg_reg  <= 1'b0;
      x_reg    <= 16'sh0;
    end
    else if (ce)
    begin
      case (st_reg)
        st_idle:
        begin
          if (avg_restart)
          begin
            cnt_reg <= 16'h0;
            sum_reg <= 32'sh0;
          end
          else if (in_hs && avg_reg == `SAL_AVG_MIN)
          begin
            // direct pass
            // The sample travels as sign and magnitude like a mean, so a zero mean is kept too.
            neg_reg <= in_data[15];
            dvd_reg <= {16'h0, in_data[15] ? 16'(-in_data) : in_data};
            st_reg  <= st_filt;
          end
          else if (in_hs && cnt_reg + 16'h1 == avg_reg)
          begin
            neg_reg  <= sum_add[31];
            dvd_reg  <= sum_add[31] ? 32'(-sum_add) : 32'(sum_add);
            rem_reg  <= 17'h0;
            step_reg <= 5'h0;
            cnt_reg  <= 16'h0;
            sum_reg  <= 32'sh0;
            st_reg   <= st_div;
          end
          else if (in_hs)
          begin
            cnt_reg <= cnt_reg + 16'h1;
            sum_reg <= sum_add;
          end
        end
        st_div:
        begin
          rem_reg  <= sub_ok ? trial - {1'b0, avg_reg} : trial;
          dvd_reg  <= {dvd_reg[30:0], sub_ok};
          step_reg <= step_reg + 5'h1;
          if (step_reg == `SAL_DIV_STEPS)
          begin
            st_reg <= st_filt;
          end
        end
        st_filt:
        begin
          x_reg  <= sal_sat16(neg_reg ? -$signed(quo) : $signed(quo));
          st_reg <= st_emit;
        end
        st_emit:
        begin
          // Back-pressure: a full readout buffer holds the stream here.
          if (fifo_in_ready)
          begin
            dvd_reg <= 32'h0;
            neg_reg <= 1'b0;
            st_reg  <= st_idle;
          end
        end
        default: st_reg <= st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-pass section, tare and output.
  // The divided mean lands in x_reg during st_filt, so the filter acts in
  // the st_emit cycle that finds room in the readout buffer, via pre-computed x; the extra cycle keeps timing short.

  assign filt_on = sal_coef(filt_reg) != 17'h0;
  assign diff    = $signed({x_reg[15], x_reg, 16'h0}) - $signed({y_reg[31], y_reg});
  assign prod    = diff * $signed({1'b0, sal_coef(filt_reg)});
  assign y_next  = y_reg + prod[47:16];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      y_reg   <= 32'sh0;
      pre_reg <= 16'sh0;
    end
    else if (ce && st_reg == st_emit && fifo_in_ready)
    begin
      y_reg   <= filt_on ? y_next : {x_reg, 16'h0};
      pre_reg <= filt_on ? y_next[31:16] : x_reg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || (ce && tare_clr))
    begin
      tare_reg <= 16'sh0;
    end
    else if (ce && tare_set)
    begin
      tare_reg <= pre_reg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid <= 1'b0;
      out_data  <= 16'sh0;
    end
    else if (ce)
    begin
      out_valid <= st_reg == st_emit && fifo_in_ready;
      if (st_reg == st_emit && fifo_in_ready)
      begin
        out_data <= sal_sat16({filt_on ? y_next[31] : x_reg[15],
                               filt_on ? y_next[31:16] : x_reg}
                              - {tare_reg[15], tare_reg});
      end
    end
  end

  sal_fifo #(.W(16), .D(16)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (out_valid),
    .in_data   (out_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  a_group_bound: assert property (cnt_reg < avg_reg)
    else $error("group counter reached count");
  a_direct_pass: assert property (in_hs && avg_reg == 16'h1 && !avg_restart
    |=> ##2 out_valid ##0 out_data == sal_sat16($past(in_data, 3) - $past(tare_reg, 1))
    or !fifo_in_ready[*1] or filt_on)
    else $error("count of one did not pass sample");
  a_no_early_out: assert property (in_hs && avg_reg > 16'h1 && cnt_reg + 16'h1 != avg_reg
    |=> st_reg == st_idle ##1 !out_valid)
    else $error("output before group end");
  a_div_length: assert property ($rose(st_reg == st_div) |-> (st_reg == st_div)[*8]
    ##24 st_reg == st_div ##1 st_reg == st_filt)
    else $error("divider length wrong");
  a_filt_bypass: assert property (st_reg == st_emit && fifo_in_ready && !filt_on
    |=> y_reg == {$past(x_reg), 16'h0})
    else $error("bypass did not track input");
  a_filt_toward: assert property (st_reg == st_emit && fifo_in_ready && filt_on
    && x_reg > $signed(y_reg[31:16]) |=> y_reg >= $past(y_reg))
    else $error("filter moved away from input");
  a_avg_write: assert property (avg_restart && avg_wr >= 16'h1 && avg_wr <= 16'hc350
    |=> avg_reg == $past(avg_wr))
    else $error("count write not applied");
  a_tare_take: assert property (tare_set && !tare_clr |=> tare_reg == $past(pre_reg))
    else $error("tare did not capture value");
  a_readout_push: assert property (out_valid && !fifo_pop
    |=> fifo_level == $past(fifo_level) + 5'h1)
    else $error("processed value not buffered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");

  c_group_done: cover property (st_reg == st_div ##32 st_reg == st_filt);
  c_filtered:   cover property (out_valid && filt_on);
  c_tared:      cover property (tare_set ##[1:20] out_valid);
  c_fifo_full:  cover property (!fifo_in_ready && st_reg == st_emit);
endmodule : sal_top
`default_nettype wire

// >>> pkg/sal_cfg.svh
`ifndef SAL_CFG_SVH
`define SAL_CFG_SVH
// Register byte offsets.
`define SAL_OFS_FILT   8'h00
`define SAL_OFS_AVG    8'h04
`define SAL_OFS_TARE   8'h08
`define SAL_OFS_VALUE  8'h0c
`define SAL_OFS_DATA   8'h10
`define SAL_OFS_STAT   8'h14
// Field positions.
`define SAL_TARE_SET_BIT  0
`define SAL_TARE_CLR_BIT  1
`define SAL_STAT_EMPTY    8
`define SAL_STAT_FULL     9
// Reset values.
`define SAL_RST_FILT   4'h0
`define SAL_RST_AVG    16'h0064
// Averaging count limits.
`define SAL_AVG_MIN    16'h0001
`define SAL_AVG_MAX    16'hc350
// Divider steps.
`define SAL_DIV_STEPS  5'h1f
// Filter gains (Q16) for fs = 10 kHz: 1 - exp(-2*pi*fc/fs).
`define SAL_COEF_5     17'h000ce
`define SAL_COEF_10    17'h0019a
`define SAL_COEF_25    17'h003fd
`define SAL_COEF_50    17'h007eb
`define SAL_COEF_100   17'h00f98
`define SAL_COEF_200   17'h01e3f
`define SAL_COEF_400   17'h038da
`define SAL_COEF_1K    17'h0776d
// Bus responses.
`define SAL_RESP_OKAY  2'h0
`define SAL_RESP_SLV   2'h2
`endif

// >>> pkg/sal_pkg.sv
package sal_pkg;
  typedef enum logic [1:0] {st_idle, st_div, st_filt, st_emit} sal_state_e;
  typedef logic signed [15:0] sal_sample_t;
endpackage : sal_pkg

// >>> design/sal_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sal_fifo
  import sal_pkg::*;
#(
  parameter int W = 16,
  parameter int D = 16
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 in_valid,
  input  wire logic [W-1:0]         in_data,
  output logic                      in_ready,
  output logic                      out_valid,
  output logic [W-1:0]              out_data,
  input  wire logic                 out_ready,
  output logic [$clog2(D):0]        level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]    mem [D];
  logic [AW-1:0]   wp_reg;
  logic [AW-1:0]   rp_reg;
  logic [AW:0]     lvl_reg;
  logic            push;
  logic            pop;

  assign in_ready  = ce && (lvl_reg != (AW+1)'(D));
  assign out_valid = ce && (lvl_reg != '0);
  assign out_data  = mem[rp_reg];
  assign level     = lvl_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      lvl_reg <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= rp_reg + 1'b1;
      end
      lvl_reg <= lvl_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    lvl_reg <= (AW+1)'(D)) else $error("fifo level above depth");
  a_fifo_count: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && push && !pop |=> lvl_reg == $past(lvl_reg) + 1'b1)
    else $error("fifo level did not grow on push");
endmodule : sal_fifo
`default_nettype wire

// >>> verif/sal_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sal_host_model (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // host writes settings
  // Address and data go out together; each is dropped once its own handshake is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output logic ok);
    int n;
    ok = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        ok = 1'b1;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////
  // host reads values
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output logic ok);
    int n;
    ok = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        ok = 1'b1;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : sal_host_model
`default_nettype wire

// >>> verif/tb_sample_averaging_lowpass.sv
`timescale 1ns/1ps
`default_nettype none
`include "sal_cfg.svh"
module tb_sample_averaging_lowpass
  import sal_pkg::*;
;
  logic        aclk, aresetn, ce, in_valid, in_ready, out_valid;
  sal_sample_t in_data, out_data;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fails, checks_done;
  logic [31:0] outq[$];
  logic [16:0] coef[8];

  sal_top DUT (.*);
  sal_host_model u_host (.*);

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Every output pulse is kept, so a test never misses a one-cycle update.
  always @(posedge aclk)
    if (aresetn && out_valid === 1'b1)
      outq.push_back({{16{out_data[15]}}, out_data});
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic hang;
    fails++;
    test_done();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    logic       ok;
    u_host.wr(a, d, r, ok);
    if (!ok)
      hang();
    chk({30'h0, r}, {30'h0, er});
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    logic        ok;
    u_host.rd(a, d, r, ok);
    if (!ok)
      hang();
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : reg_rd

  // Holds the offered sample until the block takes it.
  task automatic hand;
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (in_ready === 1'b1)
        break;
    end
    in_valid <= 1'b0;
    if (n == 200)
      hang();
  endtask : hand

  task automatic put(input sal_sample_t x);
    @(posedge aclk);
    in_valid <= 1'b1;
    in_data  <= x;
    hand();
  endtask : put

  task automatic get_out(input logic [31:0] e);
    int n;
    for (n = 0; n < 100; n++)
    begin
      if (outq.size() > 0)
        break;
      @(posedge aclk);
    end
    if (n == 100)
      hang();
    chk(outq.pop_front(), e);
  endtask : get_out

  // Empties the readout buffer so that it cannot stall the sample path.
  task automatic flush;
    logic [31:0] d;
    logic [1:0]  r;
    logic        ok;
    u_host.rd(`SAL_OFS_STAT, d, r, ok);
    repeat (d[4:0]) u_host.rd(`SAL_OFS_DATA, d, r, ok);
    if (!ok)
      hang();
  endtask : flush
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge aclk);
    hang();
  end

  initial
  begin
    int i;
    coef = '{`SAL_COEF_5, `SAL_COEF_10, `SAL_COEF_25, `SAL_COEF_50,
             `SAL_COEF_100, `SAL_COEF_200, `SAL_COEF_400, `SAL_COEF_1K};
    fails = 0;
    checks_done = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    in_valid = 1'b0;
    in_data = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    reg_rd(`SAL_OFS_FILT, 32'h0, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_AVG, 32'h64, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_TARE, 32'h0, `SAL_RESP_OKAY);
    reg_rd(8'h20, 32'h0, `SAL_RESP_SLV);
    reg_wr(8'h24, 32'h5, `SAL_RESP_SLV);
    reg_wr(`SAL_OFS_AVG, 32'hea60, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_AVG, 32'hc350, `SAL_RESP_OKAY);
    reg_wr(`SAL_OFS_AVG, 32'h0, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_AVG, 32'h1, `SAL_RESP_OKAY);
    // Fill the readout buffer until the sample path refuses, then drain it.
    reg_rd(`SAL_OFS_STAT, 32'h100, `SAL_RESP_OKAY);
    for (i = 0; i < 16; i++)
    begin
      put(16'(i * 3 - 7));
      get_out(i * 3 - 7);
    end
    reg_rd(`SAL_OFS_STAT, 32'h210, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_VALUE, 32'h26, `SAL_RESP_OKAY);
    // The sample is taken, then held in the emit stage while the buffer is full.
    put(16'sh0063);
    repeat (8) @(posedge aclk);
    chk({31'h0, in_ready}, 32'h0);
    chk(outq.size(), 32'h0);
    reg_rd(`SAL_OFS_DATA, 32'hfffffff9, `SAL_RESP_OKAY);
    get_out(32'h63);
    for (i = 1; i < 16; i++)
      reg_rd(`SAL_OFS_DATA, i * 3 - 7, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_DATA, 32'h63, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_DATA, 32'h0, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_STAT, 32'h100, `SAL_RESP_OKAY);
    // A dropped clock enable must freeze the sample path.
    @(posedge aclk);
    ce       <= 1'b0;
    in_valid <= 1'b1;
    in_data  <= 16'sh0141;
    repeat (6) @(posedge aclk);
    chk({31'h0, in_ready}, 32'h0);
    ce <= 1'b1;
    hand();
    get_out(32'h141);
    // Groups of four, with truncation toward zero on a negative sum.
    reg_wr(`SAL_OFS_AVG, 32'h4, `SAL_RESP_OKAY);
    put(16'sd10);
    put(16'sd20);
    put(16'sd30);
    repeat (40) @(posedge aclk);
    chk(outq.size(), 32'h0);
    put(-16'sd1);
    get_out(32'he);
    put(-16'sd7);
    put(-16'sd7);
    put(-16'sd7);
    put(-16'sd6);
    get_out(32'hfffffffa);
    put(16'sd3);
    put(-16'sd1);
    put(16'sd0);
    put(-16'sd1);
    get_out(32'h0);
    // Tare capture, subtraction and clear-wins.
    reg_wr(`SAL_OFS_AVG, 32'h1, `SAL_RESP_OKAY);
    put(16'sd500);
    get_out(32'h1f4);
    reg_wr(`SAL_OFS_TARE, 32'h1, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_TARE, 32'h1f4, `SAL_RESP_OKAY);
    put(16'sd700);
    get_out(32'hc8);
    reg_rd(`SAL_OFS_VALUE, 32'hc8, `SAL_RESP_OKAY);
    reg_wr(`SAL_OFS_TARE, 32'h3, `SAL_RESP_OKAY);
    reg_rd(`SAL_OFS_TARE, 32'h0, `SAL_RESP_OKAY);
    put(16'sd700);
    get_out(32'h2bc);
    // One filter step from zero toward a positive input for every cut-off.
    for (i = 0; i < 8; i++)
    begin
      flush();
      reg_wr(`SAL_OFS_FILT, 32'h0, `SAL_RESP_OKAY);
      put(16'sd0);
      get_out(32'h0);
      reg_wr(`SAL_OFS_FILT, i + 1, `SAL_RESP_OKAY);
      put(16'sh4000);
      get_out({15'h0, coef[i] >> 2});
    end
    reg_wr(`SAL_OFS_FILT, 32'h9, `SAL_RESP_OKAY);
    put(16'sh04d2);
    get_out(32'h4d2);
    reg_rd(`SAL_OFS_FILT, 32'h9, `SAL_RESP_OKAY);
    test_done();
  end
endmodule : tb_sample_averaging_lowpass
`default_nettype wire
